/* File: core/mode_ctl_pkg.sv */
// Constants for the drive link mode controller.
// Assumes a 100 MHz system clock; shared by the core and the bench.
package mode_ctl_pkg;
   // ----------------------------------------
   // Operation modes
   // ----------------------------------------
   typedef enum logic [1:0] {
      KEYPAD_MODE,
      TERMINAL_MODE,
      REMOTE_LINK_MODE
   } op_mode_e;

   // ----------------------------------------
   // Mode-selection parameter values
   // ----------------------------------------
   localparam logic [1:0] SEL_BOTH = 2'h0;
   localparam logic [1:0] SEL_KEYPAD_ONLY = 2'h1;
   localparam logic [1:0] SEL_TERMINAL_ONLY = 2'h2;

   // ----------------------------------------
   // Display codes, one per mode
   // ----------------------------------------
   localparam logic [1:0] DISP_KEYPAD = 2'h1;
   localparam logic [1:0] DISP_TERMINAL = 2'h2;
   localparam logic [1:0] DISP_REMOTE = 2'h3;

   // ----------------------------------------
   // Register offsets (plain register port)
   // ----------------------------------------
   localparam logic [3:0] REG_MODE = 4'h0;
   localparam logic [3:0] REG_MODE_SEL = 4'h1;
   localparam logic [3:0] REG_STATUS = 4'h2;
   localparam logic [3:0] REG_COMMAND = 4'h3;
   localparam logic [3:0] REG_FREQ_MON = 4'h4;
   localparam logic [3:0] REG_VOLT_MON = 4'h5;
   localparam logic [3:0] REG_FREQ_SET = 4'h6;
   localparam logic [3:0] REG_ERROR = 4'h7;

   // ----------------------------------------
   // Field positions and codes
   // ----------------------------------------
   localparam int MODE_REQ_TERMINAL_BIT = 0;
   localparam int MODE_REQ_REMOTE_BIT = 1;
   localparam logic [7:0] ERR_NONE = 8'h00;
   localparam logic [7:0] ERR_WRITE_MODE = 8'h01;
   localparam logic [1:0] SEL_RESET = 2'h0;

   // Units: frequency 0.01 Hz per LSB, voltage 0.1 V per LSB
   localparam int FREQ_LSB_CENTI_HZ = 1;
   localparam int VOLT_LSB_DECI_V = 1;

   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int CLK_MHZ = 100;
   localparam int RESP_TIME_MS = 5;
   localparam int RESP_CYCLES = RESP_TIME_MS * 1000 * CLK_MHZ;
   localparam int RESP_CNT_W = 20;
endpackage

/* File: core/resp_delay.sv */
// Delays each bit of a bus by a fixed settle time.
// Assumes inputs synchronous to SYS_CLK.
`timescale 1ns/10ps
module resp_delay #(
   parameter int W = 8,
   parameter int CYCLES = 500000
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [W-1:0] din,
   output logic [W-1:0] dout
);
   // ----------------------------------------
   // Per-bit settle counters
   // ----------------------------------------
   // Each bit follows its input only after the input held for CYCLES
   genvar i;
   for (i = 0; i < W; i++) begin : g_bit
      logic [mode_ctl_pkg::RESP_CNT_W-1:0] cnt_q, cnt_d;
      logic out_q, out_d;
      always_comb begin
         cnt_d = '0;
         out_d = out_q;
         if (din[i] != out_q) begin
            if (cnt_q == mode_ctl_pkg::RESP_CNT_W'(CYCLES - 1)) begin
               out_d = din[i];
            end else begin
               cnt_d = cnt_q + 1'b1;
            end
         end
      end
      always_ff @(posedge clk or negedge rst_b) begin
         if (!rst_b) begin
            cnt_q <= '0;
            out_q <= 1'b0;
         end else begin
            cnt_q <= cnt_d;
            out_q <= out_d;
         end
      end
      assign dout[i] = out_q;
   end
endmodule // resp_delay

/* File: core/drive_link_mode_controller.sv */
// Operation-mode controller and remote command gate for a drive link card.
// Assumes one 100 MHz clock, synchronous inputs, remote side on a register port.
`timescale 1ns/10ps
module drive_link_mode_controller (
   input wire logic SYS_CLK,
   input wire logic RST_B,
   input wire logic [3:0] ADDR,
   input wire logic [15:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [15:0] RDATA,
   input wire logic KEY_KEYPAD,
   input wire logic KEY_TERMINAL,
   input wire logic [1:0] MODE_SEL_PARAM,
   input wire logic DRIVE_RUNNING,
   input wire logic DRIVE_FWD,
   input wire logic DRIVE_REV,
   input wire logic FREQ_REACHED_FLAG,
   input wire logic OVERLOAD_FLAG,
   input wire logic POWER_DIP_FLAG,
   input wire logic FREQ_DETECT_FLAG,
   input wire logic DRIVE_FAULT,
   input wire logic [15:0] OUT_FREQ,
   input wire logic [15:0] OUT_VOLT,
   input wire logic LINK_FAIL,
   input wire logic TERM_FWD,
   input wire logic TERM_REV,
   output logic [1:0] MODE_DISPLAY,
   output logic [6:0] DRIVE_CMD,
   output logic [15:0] FREQ_SETPOINT,
   output logic PARAM_WR,
   output logic [15:0] PARAM_WDATA,
   output logic DRIVE_RESET_REQ,
   output logic LINK_HALT
);
   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   mode_ctl_pkg::op_mode_e mode_q, mode_d;
   logic [6:0] cmd_q, cmd_d;
   logic [15:0] fset_q, fset_d;
   logic [7:0] err_q, err_d;
   logic [15:0] rdata_q, rdata_d;
   logic pwr_q, pwr_d;
   logic [15:0] pwdata_q, pwdata_d;
   logic rst_req_q, rst_req_d;
   logic [1:0] disp_q, disp_d;
   logic [6:0] cmd_out_q, cmd_out_d;
   logic halt_q, halt_d;
   logic [7:0] status_raw, status_dly;
   logic [6:0] cmd_dly;
   logic stopped, remote_ok, remote_cmd_ok, wr_hit;
   logic run_req;

   // ----------------------------------------
   // Status and command settle delay
   // ----------------------------------------
   // 5 ms settle; cheap counters traded for exact latency
   assign status_raw = {DRIVE_FAULT, FREQ_DETECT_FLAG, POWER_DIP_FLAG, OVERLOAD_FLAG,
                        FREQ_REACHED_FLAG, DRIVE_REV, DRIVE_FWD, DRIVE_RUNNING};
   resp_delay #(
      .W(15),
      .CYCLES(mode_ctl_pkg::RESP_CYCLES)
   ) u_dly (
      .clk(SYS_CLK),
      .rst_b(RST_B),
      .din({cmd_q, status_raw}),
      .dout({cmd_dly, status_dly})
   );

   // ----------------------------------------
   // Preconditions
   // ----------------------------------------
   assign run_req = TERM_FWD | TERM_REV | cmd_q[0] | cmd_q[1];
   assign stopped = !DRIVE_RUNNING && !run_req;
   always_comb begin
      case (MODE_SEL_PARAM)
         mode_ctl_pkg::SEL_BOTH: remote_ok = 1'b1;
         mode_ctl_pkg::SEL_KEYPAD_ONLY: remote_ok = 1'b0;
         mode_ctl_pkg::SEL_TERMINAL_ONLY: remote_ok = 1'b1;
         default: remote_ok = 1'b0;
      endcase
   end
   assign remote_cmd_ok = mode_q == mode_ctl_pkg::REMOTE_LINK_MODE && !LINK_FAIL;
   assign wr_hit = WR && !LINK_FAIL;

   // ----------------------------------------
   // Mode machine and remote gate
   // ----------------------------------------
   always_comb begin
      mode_d = mode_q;
      cmd_d = cmd_q;
      fset_d = fset_q;
      err_d = err_q;
      pwr_d = 1'b0;
      pwdata_d = pwdata_q;
      rst_req_d = 1'b0;
      // Local keys only move between keypad and terminal
      case (mode_q)
         mode_ctl_pkg::KEYPAD_MODE: begin
            if (KEY_TERMINAL && stopped) begin
               mode_d = mode_ctl_pkg::TERMINAL_MODE;
            end
         end
         mode_ctl_pkg::TERMINAL_MODE: begin
            if (KEY_KEYPAD && stopped && MODE_SEL_PARAM != mode_ctl_pkg::SEL_TERMINAL_ONLY) begin
               mode_d = mode_ctl_pkg::KEYPAD_MODE;
            end
         end
         mode_ctl_pkg::REMOTE_LINK_MODE: begin
         end
         default: mode_d = mode_ctl_pkg::TERMINAL_MODE;
      endcase
      if (wr_hit) begin
         case (ADDR)
            mode_ctl_pkg::REG_MODE: begin
               // Keypad is never a source or target here; bad requests do nothing
               if (stopped && remote_ok) begin
                  if (WDATA[mode_ctl_pkg::MODE_REQ_REMOTE_BIT]
                      && mode_q == mode_ctl_pkg::TERMINAL_MODE) begin
                     mode_d = mode_ctl_pkg::REMOTE_LINK_MODE;
                  end else if (WDATA[mode_ctl_pkg::MODE_REQ_TERMINAL_BIT]
                               && mode_q == mode_ctl_pkg::REMOTE_LINK_MODE) begin
                     mode_d = mode_ctl_pkg::TERMINAL_MODE;
                  end
               end
            end
            mode_ctl_pkg::REG_COMMAND: begin
               if (remote_cmd_ok) begin
                  cmd_d = WDATA[6:0];
               end
            end
            mode_ctl_pkg::REG_FREQ_SET: begin
               if (remote_cmd_ok) begin
                  fset_d = WDATA;
               end
            end
            mode_ctl_pkg::REG_MODE_SEL: begin
               if (remote_cmd_ok) begin
                  if (DRIVE_RUNNING) begin
                     err_d = mode_ctl_pkg::ERR_WRITE_MODE;
                  end else begin
                     pwr_d = 1'b1;
                     pwdata_d = WDATA;
                     err_d = mode_ctl_pkg::ERR_NONE;
                  end
               end
            end
            mode_ctl_pkg::REG_ERROR: begin
               // Reset request is a write here; refused on link failure
               if (remote_cmd_ok) begin
                  rst_req_d = 1'b1;
                  mode_d = mode_ctl_pkg::TERMINAL_MODE;
                  cmd_d = '0;
                  err_d = mode_ctl_pkg::ERR_NONE;
               end
            end
            default: begin
            end
         endcase
      end
      // Leaving remote drops remote run bits so the drive is not left running
      if (mode_d != mode_ctl_pkg::REMOTE_LINK_MODE) begin
         cmd_d = '0;
      end
   end

   // ----------------------------------------
   // Mode indication and link halt
   // ----------------------------------------
   always_comb begin
      case (mode_q)
         mode_ctl_pkg::KEYPAD_MODE: disp_d = mode_ctl_pkg::DISP_KEYPAD;
         mode_ctl_pkg::TERMINAL_MODE: disp_d = mode_ctl_pkg::DISP_TERMINAL;
         mode_ctl_pkg::REMOTE_LINK_MODE: disp_d = mode_ctl_pkg::DISP_REMOTE;
         default: disp_d = mode_ctl_pkg::DISP_TERMINAL;
      endcase
      // Commands survive a halt; they return once the link is restored
      halt_d = LINK_FAIL && mode_q == mode_ctl_pkg::REMOTE_LINK_MODE;
      cmd_out_d = halt_d ? 7'h00 : cmd_dly;
   end

   // ----------------------------------------
   // Read port
   // ----------------------------------------
   always_comb begin
      rdata_d = '0;
      // Reads are served in every mode; none while the link is down
      if (RD && !LINK_FAIL) begin
         case (ADDR)
            mode_ctl_pkg::REG_MODE: rdata_d = {14'h0000, disp_q};
            mode_ctl_pkg::REG_MODE_SEL: rdata_d = pwdata_q;
            mode_ctl_pkg::REG_STATUS: rdata_d = {8'h00, status_dly};
            mode_ctl_pkg::REG_COMMAND: rdata_d = {9'h000, cmd_q};
            mode_ctl_pkg::REG_FREQ_MON: rdata_d = OUT_FREQ;
            mode_ctl_pkg::REG_VOLT_MON: rdata_d = OUT_VOLT;
            mode_ctl_pkg::REG_FREQ_SET: rdata_d = fset_q;
            mode_ctl_pkg::REG_ERROR: rdata_d = {8'h00, err_q};
            default: rdata_d = '0;
         endcase
      end
   end

   // ----------------------------------------
   // Mode and remote gate registers
   // ----------------------------------------
   always_ff @(posedge SYS_CLK or negedge RST_B) begin
      if (!RST_B) begin
         mode_q <= mode_ctl_pkg::TERMINAL_MODE;
         cmd_q <= '0;
         fset_q <= '0;
         err_q <= mode_ctl_pkg::ERR_NONE;
         pwr_q <= 1'b0;
         pwdata_q <= '0;
         rst_req_q <= 1'b0;
      end else begin
         mode_q <= mode_d;
         cmd_q <= cmd_d;
         fset_q <= fset_d;
         err_q <= err_d;
         pwr_q <= pwr_d;
         pwdata_q <= pwdata_d;
         rst_req_q <= rst_req_d;
      end
   end

   // ----------------------------------------
   // Indication registers
   // ----------------------------------------
   always_ff @(posedge SYS_CLK or negedge RST_B) begin
      if (!RST_B) begin
         disp_q <= mode_ctl_pkg::DISP_TERMINAL;
         cmd_out_q <= '0;
         halt_q <= 1'b0;
      end else begin
         disp_q <= disp_d;
         cmd_out_q <= cmd_out_d;
         halt_q <= halt_d;
      end
   end

   // ----------------------------------------
   // Read data register
   // ----------------------------------------
   always_ff @(posedge SYS_CLK or negedge RST_B) begin
      if (!RST_B) begin
         rdata_q <= '0;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   // ----------------------------------------
   // Output ports
   // ----------------------------------------
   assign RDATA = rdata_q;
   assign MODE_DISPLAY = disp_q;
   assign DRIVE_CMD = cmd_out_q;
   assign FREQ_SETPOINT = fset_q;
   assign PARAM_WR = pwr_q;
   assign PARAM_WDATA = pwdata_q;
   assign DRIVE_RESET_REQ = rst_req_q;
   assign LINK_HALT = halt_q;
endmodule // drive_link_mode_controller

/* File: tb/mode_ctl_checker.sv */
// Port assertions for the mode controller.
// Assumes one clock domain; bound to the top module below.
`timescale 1ns/10ps
module mode_ctl_checker (
   input wire logic SYS_CLK,
   input wire logic RST_B,
   input wire logic WR,
   input wire logic RD,
   input wire logic [15:0] RDATA,
   input wire logic DRIVE_RUNNING,
   input wire logic LINK_FAIL,
   input wire logic [1:0] MODE_DISPLAY,
   input wire logic [6:0] DRIVE_CMD,
   input wire logic PARAM_WR,
   input wire logic DRIVE_RESET_REQ,
   input wire logic LINK_HALT
);
   // ------
   // Properties
   // ------
   default clocking @(posedge SYS_CLK); endclocking
   default disable iff (!RST_B);
   sequence enter_remote;
      $rose(MODE_DISPLAY == 2'h3);
   endsequence
   // Display lags mode; a write just before could already have left remote
   sequence remote_fail;
      $rose(LINK_FAIL) && MODE_DISPLAY == 2'h3 && !$past(WR);
   endsequence
   rdata_idle_a: assert property (!$past(RD) |-> RDATA == 16'h0) else $error("read data not idle");
   pw_pulse_a: assert property (PARAM_WR |=> !PARAM_WR || $past(WR)) else $error("param pulse too long");
   pw_stopped_a: assert property (PARAM_WR |-> !$past(DRIVE_RUNNING)) else $error("param write while running");
   rst_pulse_a: assert property (DRIVE_RESET_REQ |=> !DRIVE_RESET_REQ) else $error("reset pulse too long");
   rst_fail_a: assert property (DRIVE_RESET_REQ |-> !$past(LINK_FAIL)) else $error("reset during link fail");
   rst_mode_a: assert property (DRIVE_RESET_REQ |-> ##[0:2] MODE_DISPLAY == 2'h2) else $error("reset mode");
   disp_code_a: assert property (MODE_DISPLAY != 2'h0) else $error("no mode shown");
   no_direct_a: assert property (MODE_DISPLAY == 2'h1 |=> MODE_DISPLAY != 2'h3) else $error("keypad to remote");
   run_lock_a: assert property (enter_remote |-> !$past(DRIVE_RUNNING, 2)) else $error("mode change running");
   fail_halt_a: assert property (remote_fail |-> ##[1:2] LINK_HALT) else $error("no halt on link fail");
   halt_cmd_a: assert property (LINK_HALT |-> DRIVE_CMD == 7'h00) else $error("commands during halt");
endmodule // mode_ctl_checker

bind drive_link_mode_controller mode_ctl_checker chk_i (.SYS_CLK, .RST_B, .WR, .RD, .RDATA, .DRIVE_RUNNING,
   .LINK_FAIL, .MODE_DISPLAY, .DRIVE_CMD, .PARAM_WR, .DRIVE_RESET_REQ, .LINK_HALT);

/* File: tb/plc_master.sv */
// Controller-side model issuing register accesses.
// Assumes read data one cycle after the strobe.
`timescale 1ns/10ps
module plc_master (
   input wire logic sys_clk,
   input wire logic [15:0] rdata,
   output logic [3:0] addr,
   output logic [15:0] wdata,
   output logic wr,
   output logic rd
);
   // ------
   // Bus tasks
   // ------
   logic [15:0] last_set = 16'h0;
   initial begin
      addr = 4'h0;
      wdata = 16'h0;
      wr = 1'b0;
      rd = 1'b0;
   end
   // Released lines show the inverse, never the old value
   task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
      @(posedge sys_clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge sys_clk);
      wr <= 1'b0;
      addr <= ~a;
      wdata <= ~d;
   endtask
   task automatic rd_reg(input logic [3:0] a, output logic [15:0] d);
      @(posedge sys_clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge sys_clk);
      rd <= 1'b0;
      addr <= ~a;
      @(posedge sys_clk);
      d = rdata;
   endtask
   task automatic setpt(input logic [15:0] f);
      if (f !== last_set) wr_reg(mode_ctl_pkg::REG_FREQ_SET, f);
      last_set = f;
   endtask
endmodule // plc_master

/* File: tb/drive_link_mode_controller_tb.sv */
// Self-checking bench for the drive link mode controller.
// Assumes the controller model drives the register port.
`timescale 1ns/10ps
module drive_link_mode_controller_tb;
   logic sys_clk = 1'b0;
   logic rst_b = 1'b0;
   logic key_kp = 1'b0;
   logic key_tm = 1'b0;
   logic [1:0] sel = 2'h0;
   logic running = 1'b0;
   logic link_fail = 1'b0;
   logic [8:0] st = 9'h000;
   logic [15:0] freq = 16'h1388;
   logic [15:0] volt = 16'h0dc0;
   logic [3:0] addr;
   logic [15:0] wdata, rdata, setp, pwdata, rv;
   logic wr, rd, pwr, rst_req, halt;
   logic [1:0] disp;
   logic [6:0] cmd;
   int n_fail = 0;
   int check_count = 0;
   int n_pw = 0;
   int n_rst = 0;
   int cycles = 0;
   // ------
   // Harness
   // ------
   always #5 sys_clk = ~sys_clk;
   plc_master m (.sys_clk, .rdata, .addr, .wdata, .wr, .rd);
   drive_link_mode_controller dut (.SYS_CLK(sys_clk), .RST_B(rst_b), .ADDR(addr), .WDATA(wdata), .WR(wr),
      .RD(rd), .RDATA(rdata), .KEY_KEYPAD(key_kp), .KEY_TERMINAL(key_tm), .MODE_SEL_PARAM(sel),
      .DRIVE_RUNNING(running), .DRIVE_FWD(st[0]), .DRIVE_REV(st[1]), .FREQ_REACHED_FLAG(st[2]),
      .OVERLOAD_FLAG(st[3]), .POWER_DIP_FLAG(st[4]), .FREQ_DETECT_FLAG(st[5]), .DRIVE_FAULT(st[6]),
      .OUT_FREQ(freq), .OUT_VOLT(volt), .LINK_FAIL(link_fail), .TERM_FWD(st[7]), .TERM_REV(st[8]),
      .MODE_DISPLAY(disp), .DRIVE_CMD(cmd), .FREQ_SETPOINT(setp), .PARAM_WR(pwr), .PARAM_WDATA(pwdata),
      .DRIVE_RESET_REQ(rst_req), .LINK_HALT(halt));
   // Status and command bits settle over 5 ms, too long for this run
   always @(posedge sys_clk) begin
      cycles++;
      if (pwr === 1'b1) n_pw++;
      if (rst_req === 1'b1) n_rst++;
      if (cycles == 20000) begin
         n_fail++;
         close_out();
      end
   end
   task automatic close_out();
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chkd(input logic [1:0] e);
      chk({14'h0, disp}, {14'h0, e});
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
   endtask
   task automatic ask(input logic [15:0] v);
      m.wr_reg(mode_ctl_pkg::REG_MODE, v);
      tick(3);
   endtask
   task automatic press(input bit kp);
      if (kp) key_kp <= 1'b1;
      else key_tm <= 1'b1;
      tick(1);
      key_kp <= 1'b0;
      key_tm <= 1'b0;
      tick(3);
   endtask
   // ------
   // Scenarios
   // ------
   task automatic t_reset();
      m.rd_reg(mode_ctl_pkg::REG_MODE, rv);
      chk(rv, 16'(mode_ctl_pkg::DISP_TERMINAL));
      chkd(mode_ctl_pkg::DISP_TERMINAL);
   endtask
   task automatic t_keypad();
      press(1'b1);
      chkd(mode_ctl_pkg::DISP_KEYPAD);
      ask(16'h0002);
      chkd(mode_ctl_pkg::DISP_KEYPAD);
      m.rd_reg(mode_ctl_pkg::REG_VOLT_MON, rv);
      chk(rv, volt);
      press(1'b0);
      chkd(mode_ctl_pkg::DISP_TERMINAL);
   endtask
   task automatic t_sel();
      sel <= mode_ctl_pkg::SEL_KEYPAD_ONLY;
      ask(16'h0002);
      chkd(mode_ctl_pkg::DISP_TERMINAL);
      sel <= mode_ctl_pkg::SEL_TERMINAL_ONLY;
      ask(16'h0002);
      chkd(mode_ctl_pkg::DISP_REMOTE);
      ask(16'h0001);
      chkd(mode_ctl_pkg::DISP_TERMINAL);
      press(1'b1);
      chkd(mode_ctl_pkg::DISP_TERMINAL);
      sel <= 2'h3;
      ask(16'h0002);
      chkd(mode_ctl_pkg::DISP_TERMINAL);
      sel <= mode_ctl_pkg::SEL_BOTH;
      ask(16'h0002);
      chkd(mode_ctl_pkg::DISP_REMOTE);
   endtask
   task automatic t_lock();
      running <= 1'b1;
      ask(16'h0001);
      chkd(mode_ctl_pkg::DISP_REMOTE);
      m.wr_reg(mode_ctl_pkg::REG_MODE_SEL, 16'h00a5);
      m.rd_reg(mode_ctl_pkg::REG_ERROR, rv);
      chk(rv, 16'(mode_ctl_pkg::ERR_WRITE_MODE));
      chk(16'(n_pw), 16'h0);
      running <= 1'b0;
      st[7] <= 1'b1;
      ask(16'h0001);
      chkd(mode_ctl_pkg::DISP_REMOTE);
      st[7] <= 1'b0;
   endtask
   task automatic t_param();
      m.wr_reg(mode_ctl_pkg::REG_MODE_SEL, 16'h1234);
      m.setpt(16'h0fa0);
      tick(2);
      chk(16'(n_pw), 16'h1);
      chk(pwdata, 16'h1234);
      chk(setp, 16'h0fa0);
      m.wr_reg(mode_ctl_pkg::REG_COMMAND, 16'h007c);
      st[2] <= 1'b1;
      m.rd_reg(mode_ctl_pkg::REG_COMMAND, rv);
      chk(rv, 16'h007c);
      chk({9'h000, cmd}, 16'h0000);
      m.rd_reg(mode_ctl_pkg::REG_STATUS, rv);
      chk(rv, 16'h0000);
      st[2] <= 1'b0;
      m.rd_reg(mode_ctl_pkg::REG_ERROR, rv);
      chk(rv, 16'(mode_ctl_pkg::ERR_NONE));
      m.rd_reg(mode_ctl_pkg::REG_FREQ_SET, rv);
      chk(rv, 16'h0fa0);
   endtask
   task automatic t_fail();
      link_fail <= 1'b1;
      tick(3);
      chk(16'(halt), 16'h1);
      m.rd_reg(mode_ctl_pkg::REG_VOLT_MON, rv);
      chk(rv, 16'h0000);
      m.wr_reg(mode_ctl_pkg::REG_ERROR, 16'h0001);
      tick(2);
      chk(16'(n_rst), 16'h0);
      link_fail <= 1'b0;
      m.wr_reg(mode_ctl_pkg::REG_ERROR, 16'h0001);
      tick(3);
      chk(16'(n_rst), 16'h1);
      chkd(mode_ctl_pkg::DISP_TERMINAL);
      m.rd_reg(mode_ctl_pkg::REG_COMMAND, rv);
      chk(rv, 16'h0000);
   endtask
   task automatic t_gate();
      m.wr_reg(mode_ctl_pkg::REG_MODE_SEL, 16'h5a5a);
      m.wr_reg(mode_ctl_pkg::REG_ERROR, 16'h0001);
      tick(2);
      chk(16'(n_pw + n_rst), 16'h2);
      chk(pwdata, 16'h1234);
      m.wr_reg(mode_ctl_pkg::REG_COMMAND, 16'h0010);
      m.rd_reg(mode_ctl_pkg::REG_COMMAND, rv);
      chk(rv, 16'h0000);
      link_fail <= 1'b1;
      tick(3);
      chk(16'(halt), 16'h0);
      link_fail <= 1'b0;
      m.rd_reg(mode_ctl_pkg::REG_FREQ_MON, rv);
      chk(rv, freq);
   endtask
   initial begin
      tick(4);
      rst_b <= 1'b1;
      t_reset();
      t_keypad();
      t_sel();
      t_lock();
      t_param();
      t_fail();
      t_gate();
      close_out();
   end
endmodule // drive_link_mode_controller_tb
